// File: verif/sfr_host_model.sv
// Host controller model for the serial flash link of the responder bench.
// Assumes the responder drives only lanes whose enables are high.
`timescale 1ns/1ps
`default_nettype none
module sfr_host_model (
  input wire logic [3:0] dut_dq_i, // Responder data out.
  input wire logic [3:0] dut_oe_i, // Responder enables.
  output logic sck_o, // Link clock, 30 ns.
  output logic cs_n_o, // Chip select.
  output logic [3:0] dq_o // Resolved data lines.
);
  logic [3:0] drv = 4'h0;
  logic saw_oe = 1'b0;
  initial sck_o = 1'b0;
  // A clean rising edge of select clears the link side before any frame.
  initial begin
    cs_n_o = 1'b0;
    #1 cs_n_o = 1'b1;
  end
  // Released lanes toggle every idle, dummy and data clock so stale data cannot pass as valid.
  assign dq_o = (dut_oe_i & dut_dq_i) | (~dut_oe_i & drv);
  task automatic tick(input logic [3:0] v, output logic [3:0] s);
    drv = v;
    #15 sck_o = 1'b1;
    s = dq_o;
    saw_oe = saw_oe | (|dut_oe_i);
    #15 sck_o = 1'b0;
  endtask : tick
  task automatic idle(input int n);
    logic [3:0] s;
    repeat (n) tick(~drv, s);
  endtask : idle
  task automatic frame(input int w, input logic [7:0] op, input logic [23:0] a,
                       input int n, output logic [7:0] d[$]);
    logic [31:0] sh;
    logic [3:0] s;
    logic [7:0] b;
    d = {};
    sh = {op, a};
    saw_oe = 1'b0;
    #7 cs_n_o = 1'b0;
    for (int i = 0; i < 32 / w; i++) begin
      tick(sh[31:28] >> (4 - w), s);
      sh = sh << w;
    end
    repeat ((w == 4) ? 10 : 8) tick(~drv, s);
    for (int k = 0; k < n; k++) begin
      for (int j = 0; j < 8 / w; j++) begin
        tick(~drv, s);
        b = (w == 1) ? {b[6:0], s[1]} : (w == 2) ? {b[5:0], s[1:0]} : {b[3:0], s};
      end
      d.push_back(b);
    end
    #7 cs_n_o = 1'b1;
    #30;
  endtask : frame
endmodule : sfr_host_model
`default_nettype wire

// File: verif/sfr_responder_asserts.sv
// Checker for the discovery-parameter responder, bound to its top ports.
// Assumes the link clock runs only while chip select is low.
`timescale 1ns/1ps
`default_nettype none
module sfr_responder_asserts
  import sfr_pkg::*;
(
  input wire logic CLK_I, // System clock.
  input wire logic RST_I, // Reset.
  input wire logic [1:0] PROTO_I, // Protocol.
  input wire sfr_ext_cfg_t EXT_CFG_I, // Options.
  input wire logic [7:0] EXT_ID_O, // ID byte.
  input wire logic BUSY_O, // Busy.
  input wire logic SCK_I, // Link clock.
  input wire logic CS_N_I, // Select.
  input wire logic [3:0] DQ_I, // Data in.
  input wire logic [3:0] DQ_O, // Data out.
  input wire logic [3:0] DQ_OE_O // Enables.
);
  logic [5:0] rise_q;
  logic [3:0] rise_dq_q;
  logic [5:0] lead;
  logic [3:0] oe_exp;
  // Counts link rising edges in the frame; saturates so long bursts stay legal.
  always_ff @(posedge SCK_I or posedge CS_N_I) begin
    if (CS_N_I) begin
      rise_q <= 6'h00;
    end else if (rise_q != 6'h3F) begin
      rise_q <= rise_q + 6'h01;
    end
  end
  // Data seen at each rising edge; it must still stand just before the next fall.
  always_ff @(posedge SCK_I) begin
    rise_dq_q <= DQ_O;
  end
  assign lead = (PROTO_I == 2'h2) ? 6'h12 : (PROTO_I == 2'h1) ? 6'h18 : 6'h28;
  assign oe_exp = (PROTO_I == 2'h2) ? 4'hF : (PROTO_I == 2'h1) ? 4'h3 : 4'h2;
  chk_oe_early: assert property (@(posedge SCK_I) disable iff (CS_N_I)
    (rise_q < lead) |-> (DQ_OE_O == 4'h0)) else $error("output driven before dummy end");
  chk_oe_lanes: assert property (@(posedge SCK_I) disable iff (CS_N_I)
    (DQ_OE_O != 4'h0) |-> (DQ_OE_O == oe_exp)) else $error("wrong data lanes driven");
  chk_dq_fall_only: assert property (@(negedge SCK_I) disable iff (CS_N_I)
    (rise_q != 6'h00) |-> (DQ_O == rise_dq_q)) else $error("data changed off falling edge");
  chk_oe_idle: assert property (@(posedge CLK_I) disable iff (RST_I)
    CS_N_I |-> (DQ_OE_O == 4'h0)) else $error("driving while deselected");
  chk_dq_idle: assert property (@(posedge CLK_I) disable iff (RST_I)
    CS_N_I |-> (DQ_O == 4'h0)) else $error("data not cleared while deselected");
  chk_busy_drop: assert property (@(posedge CLK_I) disable iff (RST_I)
    $rose(CS_N_I) |-> ##[1:4] !BUSY_O) else $error("busy stuck after deselect");
  chk_busy_cause: assert property (@(posedge CLK_I) disable iff (RST_I)
    BUSY_O |-> (!CS_N_I || !$past(CS_N_I) || !$past(CS_N_I, 2) || !$past(CS_N_I, 3)
    || !$past(CS_N_I, 4))) else $error("busy without a frame");
  chk_extid_map: assert property (@(posedge CLK_I) disable iff (RST_I)
    !$past(RST_I) |-> (EXT_ID_O == {2'h0, $past(EXT_CFG_I), 3'h0}))
    else $error("extended ID byte wrong");
  cover property (@(posedge CLK_I) $rose(BUSY_O));
  cover property (@(posedge SCK_I) DQ_OE_O == 4'h3);
  cover property (@(posedge SCK_I) DQ_OE_O == 4'hF);
endmodule : sfr_responder_asserts
bind sfr_responder sfr_responder_asserts u_chk (.CLK_I(CLK_I), .RST_I(RST_I),
  .PROTO_I(PROTO_I), .EXT_CFG_I(EXT_CFG_I), .EXT_ID_O(EXT_ID_O), .BUSY_O(BUSY_O),
  .SCK_I(SCK_I), .CS_N_I(CS_N_I), .DQ_I(DQ_I), .DQ_O(DQ_O), .DQ_OE_O(DQ_OE_O));
`default_nettype wire

// File: verif/sfr_responder_tb_top.sv
// Self-checking bench for the discovery-parameter responder.
// Assumes the host model owns the link pins and the bench the system side.
`include "sfr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module sfr_responder_tb_top;
  import sfr_pkg::*;
  localparam logic [703:0] TBL = {
    256'h53464450000100FF00000109300000FFFFFFFFFFFFFFFFFFFFFFFFFFFFFFFFFF,
    256'hFFFFFFFFFFFFFFFFFFFFFFFFFFFFFFFFE520F1FFFFFFFF0729EB076B083B27BB,
    192'hFFFFFFFFFFFF28BBFFFF2AEB0C2010D800000000FFFFFFFF};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] proto = 2'h0;
  sfr_ext_cfg_t cfg = '0;
  logic [7:0] ext_id;
  logic busy;
  logic sck;
  logic cs_n;
  logic [3:0] dq_in;
  logic [3:0] dq_out;
  logic [3:0] dq_oe;
  logic [7:0] d[$];
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;
  logic saw_busy = 1'b0;
  always #25 clk = ~clk;
  sfr_responder u_dut (.CLK_I(clk), .RST_I(rst), .PROTO_I(proto), .EXT_CFG_I(cfg),
    .EXT_ID_O(ext_id), .BUSY_O(busy), .SCK_I(sck), .CS_N_I(cs_n), .DQ_I(dq_in),
    .DQ_O(dq_out), .DQ_OE_O(dq_oe));
  sfr_host_model u_host (.dut_dq_i(dq_out), .dut_oe_i(dq_oe), .sck_o(sck),
    .cs_n_o(cs_n), .dq_o(dq_in));
  function automatic logic [7:0] exp_byte(input logic [10:0] a);
    return (a < 11'h058) ? TBL[703 - 8 * int'(a) -: 8] : 8'hFF;
  endfunction : exp_byte
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic end_sim();
    if (errors == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (busy === 1'b1) begin
      saw_busy <= 1'b1;
    end
    if (cycles == 20000) begin
      errors = errors + 1;
      end_sim();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk) cfg <= sfr_ext_cfg_t'(i[2:0]);
      repeat (2) @(posedge clk);
      check("ext_id", ext_id, {2'h0, i[2:0], 3'h0});
    end
    for (int p = 0; p < 3; p++) begin
      @(posedge clk) proto <= p[1:0];
      repeat (2) @(posedge clk);
      u_host.idle(2);
      u_host.frame(1 << p, `SFR_OPCODE, 24'h000000, 88, d);
      foreach (d[k]) begin
        if (k < 'h30) check("hdr", d[k], exp_byte(k[10:0]));
        else check("par", d[k], exp_byte(k[10:0]));
      end
      repeat (8) @(posedge clk);
      check("busy", {7'h0, busy}, 8'h00);
    end
    check("busy_seen", {7'h0, saw_busy}, 8'h01);
    // High address bits must be ignored, so this starts two bytes before the end.
    u_host.frame(4, `SFR_OPCODE, 24'hFFF7FE, 5, d);
    foreach (d[k]) check("wrap", d[k], exp_byte(11'h7FE + k[10:0]));
    u_host.frame(4, 8'h0B, 24'h000000, 2, d);
    check("refused", {7'h0, u_host.saw_oe}, 8'h00);
    u_host.frame(4, `SFR_OPCODE, 24'h000031, 1, d);
    check("restart", d[0], 8'h20);
    end_sim();
  end
endmodule : sfr_responder_tb_top
`default_nettype wire

// File: verilog/sfr_cfg.svh
// Constants for the discovery-parameter responder: opcode, phase lengths and table figures.
// Assumes inclusion by bare name from the package and the design module.
`ifndef SFR_CFG_SVH
`define SFR_CFG_SVH

`define SFR_OPCODE 8'h5A
`define SFR_CMD_BITS 5'd8
`define SFR_ADDR_BITS 5'd24
`define SFR_DUMMY_EXT 5'd8
`define SFR_DUMMY_QUAD 5'd10
`define SFR_PTR_W 11
`define SFR_BLANK 8'hFF
`define SFR_EXTID_BP_POS 5
`define SFR_EXTID_XIP_POS 4
`define SFR_EXTID_HR_POS 3
`define SFR_EXTID_RST 8'h00
`define SFR_PROTO_RST 2'h0

`endif

// File: verilog/sfr_pkg.sv
// Types shared by the discovery-parameter responder.
// Assumes sfr_cfg.svh is on the include path.
`include "sfr_cfg.svh"

package sfr_pkg;

  typedef enum logic [1:0] {
    SFR_PROTO_EXT = 2'h0,
    SFR_PROTO_DUAL = 2'h1,
    SFR_PROTO_QUAD = 2'h2
  } sfr_proto_t;

  typedef enum logic [4:0] {
    SFR_ST_CMD = 5'h01,
    SFR_ST_ADDR = 5'h02,
    SFR_ST_DUMMY = 5'h04,
    SFR_ST_DATA = 5'h08,
    SFR_ST_IGNORE = 5'h10
  } sfr_state_t;

  typedef struct packed {
    logic bp_reserved;
    logic xip_not_required;
    logic reset_pin;
  } sfr_ext_cfg_t;

endpackage : sfr_pkg

// File: verilog/sfr_responder.sv
// Serial flash discovery-parameter responder: decodes the discovery read on the
// serial link and streams the fixed 2048-byte parameter table, plus the first
// extended device ID byte. Assumes the host drives SCK_I only while CS_N_I is low
// and keeps PROTO_I static across frames.
//
// Contract
// [R1] Opcode, 24 address bits, 8 or 10 dummies
// [R2] Output starts at received address, increments
// [R3] Pointer wraps to zero after 2048 bytes
// [R4] Chip select high stops data drive
// [R5] Always continuous burst, wrap setting ignored
// [R6] Bytes 00h-03h hold SFDP signature
// [R7] Revision 1.0, one header, FFh at 07h
// [R8] Header: ID 0, rev 1.0, 9 words, 30h
// [R9] Bytes 10h to 2Fh read FFh
// [R10] Extended ID bits 5..2 report options; code sets bits 5..3 from EXT_CFG_I and holds bit 2 at zero
// [R11] Byte 30h erase, granularity fields
// [R12] Byte 31h gives 4KB erase opcode 20h
// [R13] Byte 32h fast read support flags
// [R14] Bytes 34h-37h density minus one
// [R15] Bytes 38h-39h 1-4-4 read description
// [R16] Bytes 3Ah-3Bh 1-1-4 read description
// [R17] Bytes 3Ch-3Dh 1-1-2 read description
// [R18] Bytes 3Eh-3Fh 1-2-2 read description
// [R19] Byte 40h flags 2-2-2, 4-4-4 reads
// [R20] Bytes 46h-47h 2-2-2 read, 48h-49h FFh
// [R21] Bytes 4Ah-4Bh 4-4-4 read description
// [R22] Bytes 4Ch-53h erase type list
// [R23] Address bits sampled on rising edge
// [R24] Rest reads FFh; table is constant
// [R25] Data shifts on falling edge, 1/2/4 lines
// [R26] Opcode is the standard discovery value
`include "sfr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module sfr_responder
  import sfr_pkg::*;
(
  input wire logic CLK_I, // System clock, 20 MHz.
  input wire logic RST_I, // Synchronous reset, active high.
  input wire logic [1:0] PROTO_I, // Active protocol, sfr_proto_t.
  input wire sfr_ext_cfg_t EXT_CFG_I, // Factory options for the ID byte.
  output logic [7:0] EXT_ID_O, // First extended device ID byte.
  output logic BUSY_O, // Table data is being driven.
  input wire logic SCK_I, // Serial link clock.
  input wire logic CS_N_I, // Chip select, active low.
  input wire logic [3:0] DQ_I, // Data lines in.
  output logic [3:0] DQ_O, // Data lines out.
  output logic [3:0] DQ_OE_O // Data line drive enables.
);

  // Number of data lines per clock for a protocol.
  function automatic logic [3:0] lanes(input sfr_proto_t p);
    case (p)
      SFR_PROTO_DUAL: lanes = 4'd2;
      SFR_PROTO_QUAD: lanes = 4'd4;
      default: lanes = 4'd1;
    endcase
  endfunction : lanes

  // Last clock index of a receive phase.
  function automatic logic [4:0] phase_last(input sfr_state_t s,
                                            input sfr_proto_t p);
    logic [4:0] len;
    len = 5'd1;
    case (s)
      SFR_ST_CMD: len = `SFR_CMD_BITS;
      SFR_ST_ADDR: len = `SFR_ADDR_BITS;
      default: len = 5'd1;
    endcase
    if (s == SFR_ST_DUMMY) begin
      len = (p == SFR_PROTO_QUAD) ? `SFR_DUMMY_QUAD : `SFR_DUMMY_EXT; // [R1]
    end else if (p == SFR_PROTO_DUAL) begin
      len = len >> 1;
    end else if (p == SFR_PROTO_QUAD) begin
      len = len >> 2;
    end
    phase_last = len - 5'd1;
  endfunction : phase_last

  // Shift incoming lines into the low end of the receive register.
  function automatic logic [23:0] shift_in(input logic [23:0] sh,
                                           input logic [3:0] dq,
                                           input sfr_proto_t p);
    case (p)
      SFR_PROTO_DUAL: shift_in = {sh[21:0], dq[1:0]};
      SFR_PROTO_QUAD: shift_in = {sh[19:0], dq[3:0]};
      default: shift_in = {sh[22:0], dq[0]};
    endcase
  endfunction : shift_in

  // Fixed parameter table; any location not listed reads all ones.
  function automatic logic [7:0] table_byte(input logic [10:0] a);
    case (a)
      11'h000: table_byte = 8'h53; // [R6]
      11'h001: table_byte = 8'h46; // [R6]
      11'h002: table_byte = 8'h44; // [R6]
      11'h003: table_byte = 8'h50; // [R6]
      11'h004: table_byte = 8'h00; // [R7]
      11'h005: table_byte = 8'h01; // [R7]
      11'h006: table_byte = 8'h00; // [R7]
      11'h008: table_byte = 8'h00; // [R8]
      11'h009: table_byte = 8'h00; // [R8]
      11'h00A: table_byte = 8'h01; // [R8]
      11'h00B: table_byte = 8'h09; // [R8]
      11'h00C: table_byte = 8'h30; // [R8]
      11'h00D: table_byte = 8'h00; // [R8]
      11'h00E: table_byte = 8'h00; // [R8]
      11'h030: table_byte = 8'hE5; // [R11]
      11'h031: table_byte = 8'h20; // [R12]
      11'h032: table_byte = 8'hF1; // [R13]
      11'h037: table_byte = 8'h07; // [R14]
      11'h038: table_byte = 8'h29; // [R15]
      11'h039: table_byte = 8'hEB; // [R15]
      11'h03A: table_byte = 8'h07; // [R16]
      11'h03B: table_byte = 8'h6B; // [R16]
      11'h03C: table_byte = 8'h08; // [R17]
      11'h03D: table_byte = 8'h3B; // [R17]
      11'h03E: table_byte = 8'h27; // [R18]
      11'h03F: table_byte = 8'hBB; // [R18]
      11'h046: table_byte = 8'h28; // [R20]
      11'h047: table_byte = 8'hBB; // [R20]
      11'h04A: table_byte = 8'h2A; // [R21]
      11'h04B: table_byte = 8'hEB; // [R21]
      11'h04C: table_byte = 8'h0C; // [R22]
      11'h04D: table_byte = 8'h20; // [R22]
      11'h04E: table_byte = 8'h10; // [R22]
      11'h04F: table_byte = 8'hD8; // [R22]
      11'h050: table_byte = 8'h00; // [R22]
      11'h051: table_byte = 8'h00; // [R22]
      11'h052: table_byte = 8'h00; // [R22]
      11'h053: table_byte = 8'h00; // [R22]
      // Bytes 07h, 0Fh, 10h-2Fh, 33h-36h, 40h-45h, 48h-49h and 54h up are blank.
      default: table_byte = `SFR_BLANK; // [R9] [R14] [R19] [R20] [R24]
    endcase
  endfunction : table_byte

  // Select the lines to drive for one falling edge, most significant bit first.
  function automatic logic [3:0] out_bits(input logic [7:0] b,
                                          input logic [2:0] pos,
                                          input sfr_proto_t p);
    logic [7:0] sh;
    sh = b << pos;
    case (p)
      SFR_PROTO_DUAL: out_bits = {2'b00, sh[7:6]};
      SFR_PROTO_QUAD: out_bits = sh[7:4];
      default: out_bits = {2'b00, sh[7], 1'b0};
    endcase
  endfunction : out_bits

  // Lines driven in each protocol; extended data leaves on line 1.
  function automatic logic [3:0] out_lanes(input sfr_proto_t p);
    case (p)
      SFR_PROTO_DUAL: out_lanes = 4'b0011;
      SFR_PROTO_QUAD: out_lanes = 4'b1111;
      default: out_lanes = 4'b0010;
    endcase
  endfunction : out_lanes

  // System clock side.
  logic [1:0] proto_q;
  logic [7:0] ext_id_q;
  logic busy_s1_q;
  logic busy_s2_q;
  // Link-side output stage registers, declared here because the busy
  // synchroniser below reads the enable.
  logic [3:0] dq_q;
  logic oe_q;

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      proto_q <= `SFR_PROTO_RST;
    end else begin
      proto_q <= PROTO_I;
    end
  end

  // Bit 2 is always zero (byte addressing) and the architecture field is uniform.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ext_id_q <= `SFR_EXTID_RST;
    end else begin
      ext_id_q <= `SFR_EXTID_RST; // [R10]
      ext_id_q[`SFR_EXTID_BP_POS] <= EXT_CFG_I.bp_reserved; // [R10]
      ext_id_q[`SFR_EXTID_XIP_POS] <= EXT_CFG_I.xip_not_required; // [R10]
      ext_id_q[`SFR_EXTID_HR_POS] <= EXT_CFG_I.reset_pin; // [R10]
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      busy_s1_q <= 1'b0;
      busy_s2_q <= 1'b0;
    end else begin
      busy_s1_q <= oe_q;
      busy_s2_q <= busy_s1_q;
    end
  end

  assign EXT_ID_O = ext_id_q;
  assign BUSY_O = busy_s2_q;

  // Link clock side. The protocol crosses as a quasi-static level; the flops
  // carry no reset so the value survives between frames while SCK_I is idle.
  logic [1:0] proto_s1_q;
  logic [1:0] proto_s2_q;
  sfr_proto_t proto;

  always_ff @(posedge SCK_I) begin
    proto_s1_q <= proto_q;
    proto_s2_q <= proto_s1_q;
  end

  assign proto = sfr_proto_t'(proto_s2_q);

  sfr_state_t state_q;
  sfr_state_t state_d;
  logic [4:0] cnt_q;
  logic [23:0] sh_q;
  logic [23:0] sh_d;
  logic [10:0] ptr_q;
  logic [2:0] pos_q;
  logic [3:0] pos_next;
  logic phase_end;

  assign sh_d = shift_in(sh_q, DQ_I, proto);
  assign phase_end = (cnt_q == phase_last(state_q, proto));
  assign pos_next = {1'b0, pos_q} + lanes(proto);

  always_comb begin
    state_d = state_q;
    case (state_q)
      SFR_ST_CMD: begin
        if (phase_end) begin
          state_d = (sh_d[7:0] == `SFR_OPCODE) ? SFR_ST_ADDR : SFR_ST_IGNORE; // [R26]
        end
      end
      SFR_ST_ADDR: begin
        if (phase_end) begin
          state_d = SFR_ST_DUMMY;
        end
      end
      SFR_ST_DUMMY: begin
        if (phase_end) begin
          state_d = SFR_ST_DATA; // [R1]
        end
      end
      SFR_ST_DATA: state_d = SFR_ST_DATA;
      SFR_ST_IGNORE: state_d = SFR_ST_IGNORE;
      default: state_d = SFR_ST_IGNORE;
    endcase
  end

  // Deselect clears the whole frame at once, whatever the link clock does.
  always_ff @(posedge SCK_I or posedge CS_N_I) begin
    if (CS_N_I) begin
      state_q <= SFR_ST_CMD;
      cnt_q <= 5'd0;
    end else begin
      state_q <= state_d;
      cnt_q <= (state_d != state_q) ? 5'd0 : cnt_q + 5'd1;
    end
  end

  always_ff @(posedge SCK_I or posedge CS_N_I) begin
    if (CS_N_I) begin
      sh_q <= 24'h000000;
    end else if (state_q == SFR_ST_CMD || state_q == SFR_ST_ADDR) begin
      sh_q <= sh_d; // [R23]
    end
  end

  // The pointer is only 11 bits wide, so the stream wraps at 2048 bytes and no
  // shorter burst length is honoured.
  always_ff @(posedge SCK_I or posedge CS_N_I) begin
    if (CS_N_I) begin
      ptr_q <= 11'h000;
      pos_q <= 3'd0;
    end else if (state_q == SFR_ST_ADDR && phase_end) begin
      ptr_q <= sh_d[10:0]; // [R2]
      pos_q <= 3'd0;
    end else if (state_q == SFR_ST_DATA) begin
      pos_q <= pos_next[2:0];
      if (pos_next[3]) begin
        ptr_q <= ptr_q + 11'h001; // [R2] [R3] [R5]
      end
    end
  end

  // Output stage on the falling edge.
  always_ff @(negedge SCK_I or posedge CS_N_I) begin
    if (CS_N_I) begin
      dq_q <= 4'h0;
      oe_q <= 1'b0; // [R4]
    end else begin
      dq_q <= out_bits(table_byte(ptr_q), pos_q, proto); // [R25]
      oe_q <= (state_q == SFR_ST_DATA);
    end
  end

  assign DQ_O = dq_q;
  assign DQ_OE_O = oe_q ? out_lanes(proto) : 4'b0000; // [R25]

endmodule : sfr_responder

`default_nettype wire
